// [plkd_pkg.sv]
/*
 * Shared constants for the lock detector: register offsets on the serial
 * port, field positions, reset values and window timing.
 * Assumes a 20 MHz comparison clock and a 6-bit serial register address.
 */
package plkd_pkg;

	// Clock and timing
	localparam int CLK_MHZ = 20;
	localparam int ANALOG_WIN_NS = 10;
	// Longest time rounds down, never below one cycle
	localparam int ANALOG_WIN_RAW = (ANALOG_WIN_NS * CLK_MHZ) / 1000;
	localparam int ANALOG_WIN_CYC = (ANALOG_WIN_RAW < 1) ? 1 : ANALOG_WIN_RAW;
	localparam int RING_BASE_CYC = 1;
	localparam int SKEW_OFFSET_CYC = 2;
	localparam int MEAS_MAX_CYC = 255;

	// Serial frame: 1 direction bit, 6 address bits, 24 data bits
	localparam int SER_ADDR_W = 6;
	localparam int SER_DATA_W = 24;
	localparam logic [5:0] SER_LAST_BIT = 6'h1e;
	localparam logic [5:0] SER_ADDR_BIT = 6'h06;

	// Register offsets
	localparam logic [5:0] OFS_CORE_ENABLE = 6'h01;
	localparam logic [5:0] OFS_PUMP_CTRL = 6'h05;
	localparam logic [5:0] OFS_LOCK_WINDOW = 6'h1a;
	localparam logic [5:0] OFS_GPO_SELECT = 6'h1b;
	localparam logic [5:0] OFS_LOCK_STATUS = 6'h1f;

	// Field positions
	localparam int CORE_LOCK_EN_BIT = 11;
	localparam int PUMP_UP_ALLOW_BIT = 1;
	localparam int PUMP_DN_ALLOW_BIT = 2;
	localparam int WIN_TARGET_LSB = 0;
	localparam int WIN_TARGET_W = 10;
	localparam int WIN_SKEW_EN_BIT = 10;
	localparam int WIN_SKEW_LATE_BIT = 11;
	localparam int WIN_SHARE_BIT = 12;
	localparam int WIN_FORCE_BIT = 13;
	localparam int WIN_DIGITAL_BIT = 14;
	localparam int WIN_RING_CFG_LSB = 15;
	localparam int WIN_DURATION_LSB = 17;
	localparam int WIN_RING_OBS_BIT = 19;
	localparam int GPO_SEL_LSB = 0;
	localparam logic [3:0] GPO_SEL_RING = 4'h7;
	localparam int STATUS_LOCK_BIT = 0;

	// Reset values
	localparam logic [23:0] RST_CORE_ENABLE = 24'h000000;
	localparam logic [23:0] RST_PUMP_CTRL = 24'h000006;
	localparam logic [23:0] RST_LOCK_WINDOW = 24'h000000;
	localparam logic [23:0] RST_GPO_SELECT = 24'h000000;

endpackage

// [plkd_phase_meter.sv]
/*
 * Measures the signed time from a reference arrival to the next oscillator
 * arrival (negative when the oscillator comes first), in clock cycles.
 * Assumes single-cycle arrival pulses synchronous to clk.
 */
`timescale 1ns/1ps
module plkd_phase_meter
	import plkd_pkg::*;
#(
	parameter int MAX_CYC = MEAS_MAX_CYC,
	parameter int CW = 9
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic ref_pulse,
	input wire logic vco_pulse,
	output logic meas_valid,
	output logic meas_timeout,
	output logic signed [CW:0] meas_diff
);

	typedef enum logic [1:0] {
		PLKD_IDLE = 2'b00,
		PLKD_REF_FIRST = 2'b01,
		PLKD_VCO_FIRST = 2'b10
	} plkd_meas_t;

	plkd_meas_t state_ff;
	plkd_meas_t nxt_state;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic at_max;

	assign at_max = (cnt_ff == CW'(MAX_CYC));

	// Pair the first arrival of either signal with the next arrival of the other
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + 1'b1;
		meas_valid = 1'b0;
		meas_timeout = 1'b0;
		meas_diff = '0;
		unique case (state_ff)
			PLKD_IDLE:
			begin
				nxt_cnt = '0;
				if (ref_pulse && vco_pulse)
					meas_valid = 1'b1;
				else if (ref_pulse)
					nxt_state = PLKD_REF_FIRST;
				else if (vco_pulse)
					nxt_state = PLKD_VCO_FIRST;
			end
			PLKD_REF_FIRST:
			begin
				meas_diff = $signed({1'b0, cnt_ff + 1'b1});
				if (vco_pulse || at_max)
				begin
					meas_valid = 1'b1;
					meas_timeout = !vco_pulse;
					nxt_state = PLKD_IDLE;
				end
			end
			PLKD_VCO_FIRST:
			begin
				meas_diff = -$signed({1'b0, cnt_ff + 1'b1});
				if (ref_pulse || at_max)
				begin
					meas_valid = 1'b1;
					meas_timeout = !ref_pulse;
					nxt_state = PLKD_IDLE;
				end
			end
			default:
				nxt_state = PLKD_IDLE;
		endcase
		if (!run)
		begin
			nxt_state = PLKD_IDLE;
			meas_valid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= PLKD_IDLE;
			cnt_ff <= '0;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

endmodule

// [plkd_lock_detect.sv]
/*
 * Lock detector with charge-pump gating, a synchronous serial register port
 * and the shared lock / serial-data pin.
 * Assumes all inputs, including the serial port pins, are synchronous to clk.
 */
`timescale 1ns/1ps

// Summary of operation
// - Both pump allow bits clear puts the pump output in high impedance.
// - Up allow bit gates up pulses; down allow bit gates down pulses.
// - Lock detection runs only while lock watch enable is set.
// - Window source clear selects a fixed nominal 10 ns window.
// - Window source set selects a digital window timed by the ring oscillator.
// - Two-bit ring setting and two-bit length field set digital window length.
// - Ring observe with selector 0111 shows ring on line two; detection stops.
// - Lock flag sets once consecutive in-window arrivals reach the ten-bit target.
// - One arrival outside the window clears the lock flag at once.
// - Lock flag is read-only and readable over the serial port.
// - Force bit drives the lock flag onto the shared pin continuously.
// - Share bit shows lock flag except during a serial read.
// - Late skew shifts the window after the reference by a fixed offset.
// - Early skew shifts the window ahead of the reference edge.
module plkd_lock_detect
	import plkd_pkg::*;
#(
	parameter int TARGET_W = WIN_TARGET_W,
	parameter int SKEW_CYC = SKEW_OFFSET_CYC,
	parameter int RING_CYC = RING_BASE_CYC
)
(
	input wire logic clk,
	input wire logic ce,
	input wire logic nrst,
	input wire logic ser_cs_n,
	input wire logic ser_clk,
	input wire logic ser_din,
	input wire logic ref_pulse,
	input wire logic vco_pulse,
	input wire logic pfd_up,
	input wire logic pfd_dn,
	output logic cp_up,
	output logic cp_dn,
	output logic cp_hiz,
	output logic lock_or_serial_out_pin,
	output logic gp_out_line_two,
	output logic lock_flag
);

	localparam int CW = 9;

	// Register file and serial port state
	logic [23:0] core_enable_controls_ff;
	logic [23:0] pump_ctrl_ff;
	logic [23:0] lock_window_config_ff;
	logic [23:0] gpo_select_ff;
	logic [23:0] nxt_core_enable_controls;
	logic [23:0] nxt_pump_ctrl;
	logic [23:0] nxt_lock_window_config;
	logic [23:0] nxt_gpo_select;
	logic sclk_prev_ff;
	logic [5:0] bit_cnt_ff;
	logic [29:0] sin_ff;
	logic [SER_DATA_W-1:0] sout_ff;
	logic rd_act_ff;
	logic [5:0] nxt_bit_cnt;
	logic [29:0] nxt_sin;
	logic [SER_DATA_W-1:0] nxt_sout;
	logic nxt_rd_act;
	logic sclk_rise;
	logic [30:0] frame;
	logic [SER_ADDR_W-1:0] rd_addr;
	logic [23:0] rd_data;

	// Lock state
	logic lock_ff;
	logic [TARGET_W-1:0] run_cnt_ff;
	logic nxt_lock;
	logic [TARGET_W-1:0] nxt_run_cnt;
	logic [TARGET_W-1:0] target;
	logic detect_run;
	logic meas_valid;
	logic meas_timeout;
	logic signed [CW:0] meas_diff;
	logic signed [CW:0] win_len;
	logic signed [CW:0] win_lo;
	logic signed [CW:0] win_hi;
	logic in_window;
	logic [1:0] ring_cfg;
	logic [1:0] duration;

	// Ring oscillator model and outputs
	logic ring_ff;
	logic [4:0] ring_cnt_ff;
	logic nxt_ring;
	logic [4:0] nxt_ring_cnt;
	logic [4:0] ring_half;
	logic cp_up_ff;
	logic cp_dn_ff;
	logic cp_hiz_ff;
	logic pin_ff;
	logic gp2_ff;
	logic nxt_cp_up;
	logic nxt_cp_dn;
	logic nxt_cp_hiz;
	logic nxt_pin;
	logic nxt_gp2;
	logic up_allow;
	logic dn_allow;
	logic ring_observe;

	assign up_allow = pump_ctrl_ff[PUMP_UP_ALLOW_BIT];
	assign dn_allow = pump_ctrl_ff[PUMP_DN_ALLOW_BIT];
	assign ring_observe = lock_window_config_ff[WIN_RING_OBS_BIT];
	assign ring_cfg = lock_window_config_ff[WIN_RING_CFG_LSB +: 2];
	assign duration = lock_window_config_ff[WIN_DURATION_LSB +: 2];
	assign target = lock_window_config_ff[WIN_TARGET_LSB +: TARGET_W];
	assign sclk_rise = ser_clk && !sclk_prev_ff && !ser_cs_n;
	assign frame = {sin_ff, ser_din};
	assign rd_addr = {sin_ff[4:0], ser_din};

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		rd_data = 24'h000000;
		unique case (rd_addr)
			OFS_CORE_ENABLE: rd_data = core_enable_controls_ff;
			OFS_PUMP_CTRL: rd_data = pump_ctrl_ff;
			OFS_LOCK_WINDOW: rd_data = lock_window_config_ff;
			OFS_GPO_SELECT: rd_data = gpo_select_ff;
			OFS_LOCK_STATUS: rd_data[STATUS_LOCK_BIT] = lock_ff;
			default: rd_data = 24'h000000;
		endcase
	end

	// Serial port: direction bit, address, then 24 data bits, MSB first
	always_comb
	begin
		nxt_bit_cnt = bit_cnt_ff;
		nxt_sin = sin_ff;
		nxt_sout = sout_ff;
		nxt_rd_act = rd_act_ff;
		nxt_core_enable_controls = core_enable_controls_ff;
		nxt_pump_ctrl = pump_ctrl_ff;
		nxt_lock_window_config = lock_window_config_ff;
		nxt_gpo_select = gpo_select_ff;
		if (ser_cs_n)
		begin
			nxt_bit_cnt = 6'h00;
			nxt_rd_act = 1'b0;
		end
		else if (sclk_rise)
		begin
			nxt_sin = frame[29:0];
			if (bit_cnt_ff != SER_LAST_BIT)
				nxt_bit_cnt = bit_cnt_ff + 6'h01;
			if (rd_act_ff)
				nxt_sout = {sout_ff[SER_DATA_W-2:0], 1'b0};
			if (bit_cnt_ff == SER_ADDR_BIT && sin_ff[5])
			begin
				// Read frame: unless the force bit is set, the pin turns to serial data until the frame ends
				nxt_rd_act = 1'b1;
				nxt_sout = rd_data;
			end
			if (bit_cnt_ff == SER_LAST_BIT && !frame[30])
			begin
				// Status register has no write path, so it stays read-only
				unique case (frame[29:24])
					OFS_CORE_ENABLE: nxt_core_enable_controls = frame[23:0];
					OFS_PUMP_CTRL: nxt_pump_ctrl = frame[23:0];
					OFS_LOCK_WINDOW: nxt_lock_window_config = frame[23:0];
					OFS_GPO_SELECT: nxt_gpo_select = frame[23:0];
					default: nxt_pump_ctrl = pump_ctrl_ff;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_prev_ff <= 1'b0;
			bit_cnt_ff <= 6'h00;
			sin_ff <= 30'h00000000;
			sout_ff <= 24'h000000;
			rd_act_ff <= 1'b0;
			core_enable_controls_ff <= RST_CORE_ENABLE;
			pump_ctrl_ff <= RST_PUMP_CTRL;
			lock_window_config_ff <= RST_LOCK_WINDOW;
			gpo_select_ff <= RST_GPO_SELECT;
		end
		else if (ce)
		begin
			sclk_prev_ff <= ser_clk;
			bit_cnt_ff <= nxt_bit_cnt;
			sin_ff <= nxt_sin;
			sout_ff <= nxt_sout;
			rd_act_ff <= nxt_rd_act;
			core_enable_controls_ff <= nxt_core_enable_controls;
			pump_ctrl_ff <= nxt_pump_ctrl;
			lock_window_config_ff <= nxt_lock_window_config;
			gpo_select_ff <= nxt_gpo_select;
		end
	end

	// Detection stops while the ring oscillator is being observed
	assign detect_run = core_enable_controls_ff[CORE_LOCK_EN_BIT] && !ring_observe;

	plkd_phase_meter #(
		.MAX_CYC(MEAS_MAX_CYC),
		.CW(CW)
	) u_meter (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.run(detect_run),
		.ref_pulse(ref_pulse),
		.vco_pulse(vco_pulse),
		.meas_valid(meas_valid),
		.meas_timeout(meas_timeout),
		.meas_diff(meas_diff)
	);

	// Window bounds in cycles relative to the reference edge; software must
	// make the window cover the expected offset and modulation spread
	always_comb
	begin
		if (lock_window_config_ff[WIN_DIGITAL_BIT])
			win_len = $signed((CW+1)'((duration + 1) * (ring_cfg + 1) * RING_CYC));
		else
			win_len = $signed((CW+1)'(ANALOG_WIN_CYC));
		win_lo = -win_len;
		win_hi = win_len;
		if (lock_window_config_ff[WIN_SKEW_EN_BIT])
		begin
			if (lock_window_config_ff[WIN_SKEW_LATE_BIT])
			begin
				win_lo = $signed((CW+1)'(SKEW_CYC));
				win_hi = win_lo + win_len;
			end
			else
			begin
				win_hi = -$signed((CW+1)'(SKEW_CYC));
				win_lo = win_hi - win_len;
			end
		end
		in_window = !meas_timeout && meas_diff >= win_lo && meas_diff <= win_hi;
	end

	// Lock run counter and flag
	always_comb
	begin
		nxt_lock = lock_ff;
		nxt_run_cnt = run_cnt_ff;
		if (!detect_run)
			nxt_run_cnt = '0;
		else if (meas_valid)
		begin
			if (!in_window)
			begin
				nxt_lock = 1'b0;
				nxt_run_cnt = '0;
			end
			else
			begin
				if (run_cnt_ff != {TARGET_W{1'b1}})
					nxt_run_cnt = run_cnt_ff + 1'b1;
				if (run_cnt_ff + 1'b1 >= target)
					nxt_lock = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lock_ff <= 1'b0;
			run_cnt_ff <= '0;
		end
		else if (ce)
		begin
			lock_ff <= nxt_lock;
			run_cnt_ff <= nxt_run_cnt;
		end
	end

	// Ring oscillator stand-in: half period set by the ring setting field
	assign ring_half = 5'((ring_cfg + 1) * RING_CYC);
	always_comb
	begin
		nxt_ring = ring_ff;
		nxt_ring_cnt = ring_cnt_ff + 5'h01;
		if (ring_cnt_ff + 5'h01 >= ring_half)
		begin
			nxt_ring = !ring_ff;
			nxt_ring_cnt = 5'h00;
		end
	end

	// Output stage; every output comes straight from a flip-flop
	always_comb
	begin
		nxt_cp_up = pfd_up && up_allow;
		nxt_cp_dn = pfd_dn && dn_allow;
		nxt_cp_hiz = !up_allow && !dn_allow;
		nxt_gp2 = 1'b0;
		if (ring_observe && gpo_select_ff[GPO_SEL_LSB +: 4] == GPO_SEL_RING)
			nxt_gp2 = ring_ff;
		// Force wins over share; with neither the pin is plain serial data
		if (lock_window_config_ff[WIN_FORCE_BIT])
			nxt_pin = lock_ff;
		else if (lock_window_config_ff[WIN_SHARE_BIT] && !rd_act_ff)
			nxt_pin = lock_ff;
		else
			nxt_pin = rd_act_ff && sout_ff[SER_DATA_W-1];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ring_ff <= 1'b0;
			ring_cnt_ff <= 5'h00;
			cp_up_ff <= 1'b0;
			cp_dn_ff <= 1'b0;
			cp_hiz_ff <= 1'b0;
			pin_ff <= 1'b0;
			gp2_ff <= 1'b0;
		end
		else if (ce)
		begin
			ring_ff <= nxt_ring;
			ring_cnt_ff <= nxt_ring_cnt;
			cp_up_ff <= nxt_cp_up;
			cp_dn_ff <= nxt_cp_dn;
			cp_hiz_ff <= nxt_cp_hiz;
			pin_ff <= nxt_pin;
			gp2_ff <= nxt_gp2;
		end
	end

	assign cp_up = cp_up_ff;
	assign cp_dn = cp_dn_ff;
	assign cp_hiz = cp_hiz_ff;
	assign lock_or_serial_out_pin = pin_ff;
	assign gp_out_line_two = gp2_ff;
	assign lock_flag = lock_ff;

endmodule

// [plkd_lock_detect_sva.sv]
/*
 * Checker for the lock detector: pump gating, lock flag timing and the
 * shared lock / serial-data pin.
 * Assumes it is bound to plkd_lock_detect and sees only its ports.
 */
`timescale 1ns/1ps
module plkd_lock_detect_sva
(
	input wire logic clk,
	input wire logic ce,
	input wire logic nrst,
	input wire logic ser_cs_n,
	input wire logic ser_clk,
	input wire logic ser_din,
	input wire logic ref_pulse,
	input wire logic vco_pulse,
	input wire logic pfd_up,
	input wire logic pfd_dn,
	input wire logic cp_up,
	input wire logic cp_dn,
	input wire logic cp_hiz,
	input wire logic lock_or_serial_out_pin,
	input wire logic gp_out_line_two,
	input wire logic lock_flag
);
	// One clock domain, so a single default clocking and disable
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Pump outputs only ever follow a detector request
	AST_UP_GATE: assert property ($past(ce) && cp_up |-> $past(pfd_up))
		else $error("pump up without detector up");
	AST_DN_GATE: assert property ($past(ce) && cp_dn |-> $past(pfd_dn))
		else $error("pump down without detector down");
	AST_HIZ_QUIET: assert property (cp_hiz |-> !cp_up && !cp_dn)
		else $error("pump drives while floating");
	// Registers are stable while the port is idle, so a request must show somewhere
	AST_PUMP_LIVE: assert property (ce && ser_cs_n && pfd_up && pfd_dn |=>
		cp_up || cp_dn || cp_hiz)
		else $error("both requests lost without floating");
	AST_LOCK_CAUSE: assert property ($rose(lock_flag) |->
		$past(vco_pulse) || $past(ref_pulse) || $past(vco_pulse, 2) || $past(ref_pulse, 2))
		else $error("lock set without an arrival");
	// A two-cycle look-back covers every cycle of the faster ring settings
	AST_RING_FREEZE: assert property ($changed(gp_out_line_two)
		|| gp_out_line_two != $past(gp_out_line_two, 2) |-> $stable(lock_flag))
		else $error("lock flag moved during ring observe");
	// With the port idle the pin is either the flag or low
	AST_PIN_IDLE: assert property (ser_cs_n [*4] ##0
		(lock_or_serial_out_pin && $stable(lock_flag)) |-> lock_flag)
		else $error("idle pin high without lock");
	AST_PIN_HOLD: assert property ((!ser_cs_n && !ser_clk) [*3] ##0
		($stable(lock_flag) && $past(lock_flag) == $past(lock_flag, 2))
		|-> $stable(lock_or_serial_out_pin))
		else $error("pin moved without a shift");

	cover property ($rose(lock_flag));
	cover property ($fell(lock_flag));
	cover property (cp_hiz);
	cover property ($changed(gp_out_line_two));
endmodule

bind plkd_lock_detect plkd_lock_detect_sva u_sva (.clk(clk), .ce(ce), .nrst(nrst),
	.ser_cs_n(ser_cs_n), .ser_clk(ser_clk), .ser_din(ser_din), .ref_pulse(ref_pulse),
	.vco_pulse(vco_pulse), .pfd_up(pfd_up), .pfd_dn(pfd_dn), .cp_up(cp_up), .cp_dn(cp_dn),
	.cp_hiz(cp_hiz), .lock_or_serial_out_pin(lock_or_serial_out_pin),
	.gp_out_line_two(gp_out_line_two), .lock_flag(lock_flag));

// [tb_pll_lock_detect.sv]
/*
 * Testbench for the lock detector: register access, pump gating, lock
 * counting, window modes, shared pin and ring observe.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/1ps
module tb_pll_lock_detect
	import plkd_pkg::*;
;
	logic clk, ce, nrst, ser_cs_n, ser_clk, ser_din, ref_pulse, vco_pulse, pfd_up, pfd_dn;
	logic cp_up, cp_dn, cp_hiz, ld_pin, gp_two, lock_flag;
	logic [23:0] rdat;
	int n_errors = 0;
	int checks_done = 0;

	plkd_lock_detect u_dut (.clk(clk), .ce(ce), .nrst(nrst), .ser_cs_n(ser_cs_n),
		.ser_clk(ser_clk), .ser_din(ser_din), .ref_pulse(ref_pulse), .vco_pulse(vco_pulse),
		.pfd_up(pfd_up), .pfd_dn(pfd_dn), .cp_up(cp_up), .cp_dn(cp_dn), .cp_hiz(cp_hiz),
		.lock_or_serial_out_pin(ld_pin), .gp_out_line_two(gp_two), .lock_flag(lock_flag));

	// 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One frame, MSB first; ser_clk low three samples so a rise is never missed
	task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] data);
		logic [30:0] word;
		word = {rd, addr, data};
		@(posedge clk);
		ser_cs_n <= 1'b0;
		for (int i = 30; i >= 0; i--)
		begin
			@(posedge clk);
			ser_clk <= 1'b0;
			ser_din <= word[i];
			@(posedge clk);
			#1;
			if (i < 24)
				rdat[i] = ld_pin;
			@(posedge clk);
			@(posedge clk);
			ser_clk <= 1'b1;
			@(posedge clk);
		end
		@(posedge clk);
		ser_cs_n <= 1'b1;
		ser_clk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// Two arrivals gap cycles apart; each signal is assigned once per edge
	task automatic pair(input logic vco_first, input int gap);
		@(posedge clk);
		ref_pulse <= !vco_first;
		vco_pulse <= vco_first;
		for (int k = 1; k <= gap; k++)
		begin
			@(posedge clk);
			ref_pulse <= (k == gap) && vco_first;
			vco_pulse <= (k == gap) && !vco_first;
		end
		@(posedge clk);
		ref_pulse <= 1'b0;
		vco_pulse <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset();
		logic [5:0] ofs [6] = '{OFS_CORE_ENABLE, OFS_PUMP_CTRL, OFS_LOCK_WINDOW,
			OFS_GPO_SELECT, OFS_LOCK_STATUS, 6'h3f};
		logic [23:0] rv [6] = '{RST_CORE_ENABLE, RST_PUMP_CTRL, RST_LOCK_WINDOW,
			RST_GPO_SELECT, 24'h0, 24'h0};
		#1;
		chk(24'({cp_up, cp_dn, cp_hiz, lock_flag, ld_pin, gp_two}), 24'h0);
		for (int k = 0; k < 6; k++)
		begin
			frame(1'b1, ofs[k], 24'h0);
			chk(rdat, rv[k]);
		end
	endtask

	task automatic t_pump();
		pfd_up <= 1'b1;
		pfd_dn <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			frame(1'b0, OFS_PUMP_CTRL, 24'(m << 1));
			#1;
			chk(24'({cp_up, cp_dn, cp_hiz}), 24'({m[0], m[1], m == 0}));
		end
		@(posedge clk);
		pfd_up <= 1'b0;
		frame(1'b0, OFS_PUMP_CTRL, RST_PUMP_CTRL);
		#1;
		chk(24'({cp_up, cp_dn}), 24'h1);
	endtask

	// Three in-window arrivals in a row, flag rising only on the last
	task automatic run3();
		for (int k = 1; k <= 3; k++)
		begin
			pair(1'b0, 1);
			chk(24'(lock_flag), 24'(k == 3));
		end
	endtask

	task automatic t_lock();
		frame(1'b0, OFS_LOCK_WINDOW, 24'h001003);
		frame(1'b0, OFS_CORE_ENABLE, 24'h000800);
		run3();
		chk(24'(ld_pin), 24'h1);
		frame(1'b1, OFS_LOCK_STATUS, 24'h0);
		chk(rdat, 24'h000001);
		chk(24'(ld_pin), 24'h1);
		frame(1'b0, OFS_LOCK_STATUS, 24'h0);
		frame(1'b1, OFS_LOCK_STATUS, 24'h0);
		chk(rdat, 24'h000001);
		pair(1'b0, 5);
		chk(24'(lock_flag), 24'h0);
		run3();
		frame(1'b0, OFS_CORE_ENABLE, 24'h0);
		pair(1'b0, 5);
		chk(24'(lock_flag), 24'h1);
		frame(1'b0, OFS_LOCK_WINDOW, 24'h002003);
		frame(1'b1, OFS_LOCK_STATUS, 24'h0);
		chk(rdat, 24'hffffff);
		frame(1'b0, OFS_CORE_ENABLE, 24'h000800);
	endtask

	// Target one; each entry flips the flag, boundaries of every window kind
	task automatic t_window();
		logic [23:0] cfg [8] = '{24'h001c01, 24'h001c01, 24'h001401, 24'h001401,
			24'h06d001, 24'h06d001, 24'h001001, 24'h001001};
		logic vf [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		int gap [8] = '{1, 3, 1, 3, 9, 8, 2, 1};
		for (int k = 0; k < 8; k++)
		begin
			frame(1'b0, OFS_LOCK_WINDOW, cfg[k]);
			pair(vf[k], gap[k]);
			chk(24'(lock_flag), 24'(k % 2));
		end
		// Clock enable low freezes everything, so even a miss leaves the flag set
		ce <= 1'b0;
		pair(1'b0, 9);
		chk(24'(lock_flag), 24'h1);
		ce <= 1'b1;
	endtask

	task automatic t_ring();
		logic prev;
		int n;
		n = 0;
		frame(1'b0, OFS_GPO_SELECT, 24'h000007);
		frame(1'b0, OFS_LOCK_WINDOW, 24'h089001);
		#1;
		for (int k = 0; k < 8; k++)
		begin
			prev = gp_two;
			@(posedge clk);
			#1;
			n += int'(gp_two !== prev);
		end
		chk(24'(n), 24'h4);
		pair(1'b0, 9);
		chk(24'(lock_flag), 24'h1);
		frame(1'b0, OFS_LOCK_WINDOW, 24'h001001);
		chk(24'(gp_two), 24'h0);
		pair(1'b0, 9);
		chk(24'(lock_flag), 24'h0);
		// A reference whose partner never comes times out and counts as a miss
		pair(1'b0, 1);
		chk(24'(lock_flag), 24'h1);
		ref_pulse <= 1'b1;
		@(posedge clk);
		ref_pulse <= 1'b0;
		repeat (MEAS_MAX_CYC + 5) @(posedge clk);
		chk(24'(lock_flag), 24'h0);
	endtask

	initial
	begin
		ce = 1'b1;
		nrst = 1'b0;
		ser_cs_n = 1'b1;
		ser_clk = 1'b0;
		ser_din = 1'b0;
		ref_pulse = 1'b0;
		vco_pulse = 1'b0;
		pfd_up = 1'b0;
		pfd_dn = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_pump();
		t_lock();
		t_window();
		t_ring();
		finish_test();
	end

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		finish_test();
	end
endmodule
